// *** rtl/stc_top.sv ***
// top: APB register slave around the packet timestamp counter
//
// Summary of operation
// - 32-bit counter steps every X cycles
// - all-ones wraps to zero, keeps counting
// - enable low holds counter value
// - count write loads full 32 bits
// - count read returns live value, no effect
// - enable bit 0, resets zero, rest zero
// - divider n gives period n+1 cycles
// - disable or count write restarts prescale
//
// Design decision made here: the APB register port.
`default_nettype none
module stc_top
	import stc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [STC_ADDR_W-1:0] paddr,
	input wire logic [STC_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [STC_DATA_W-1:0] prdata
);
	////////////////////////////////////////////////////////////////////////////////
	stc_apb_req_t req;
	stc_apb_rsp_t rsp_r;
	stc_load_t ld;
	logic en_r;
	logic [STC_DIV_W-1:0] div_r;
	logic [STC_DATA_W-1:0] count;
	logic step;
	logic setup;
	logic access;
	logic wr_en;
	logic wr_cnt;
	logic wr_div;
	logic mapped;
	logic restart;
	logic [STC_DATA_W-1:0] rd_nxt;
	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
	assign pready = rsp_r.ready;
	assign pslverr = rsp_r.slverr;
	assign prdata = rsp_r.rdata;
	// no wait state: setup cycle prepares the answer, first access cycle completes
	assign setup = req.sel && !req.enable;
	// writes commit only at the completing access edge
	assign access = req.sel && req.enable && rsp_r.ready;
	assign mapped = (req.addr == STC_OFF_IDENT) || (req.addr == STC_OFF_COUNT) ||
		(req.addr == STC_OFF_ENABLE) || (req.addr == STC_OFF_DIVIDE);
	assign wr_cnt = access && req.write && req.addr == STC_OFF_COUNT;
	assign wr_en = access && req.write && req.addr == STC_OFF_ENABLE;
	assign wr_div = access && req.write && req.addr == STC_OFF_DIVIDE;
	assign ld = '{load: wr_cnt, value: req.wdata};
	// disable or fresh load restarts the prescale count
	assign restart = wr_cnt || (wr_en && !req.wdata[STC_EN_BIT]);
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r <= STC_EN_RESET;
		end else if (wr_en) begin
			en_r <= req.wdata[STC_EN_BIT];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= STC_DIV_RESET;
		end else if (wr_div) begin
			div_r <= req.wdata[STC_DIV_LSB +: STC_DIV_W];
		end
	end
	always_comb begin
		rd_nxt = '0;
		case (req.addr)
			STC_OFF_IDENT: rd_nxt = STC_IDENT_VALUE;
			STC_OFF_COUNT: rd_nxt = count;
			STC_OFF_ENABLE: rd_nxt[STC_EN_BIT] = en_r;
			STC_OFF_DIVIDE: rd_nxt[STC_DIV_LSB +: STC_DIV_W] = div_r;
			default: rd_nxt = '0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_r <= '0;
		end else if (setup) begin
			rsp_r.ready <= 1'b1;
			rsp_r.slverr <= !mapped;
			rsp_r.rdata <= req.write ? '0 : rd_nxt;
		end else begin
			rsp_r <= '0;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	stc_prescaler u_pre (
		.pclk(pclk),
		.presetn(presetn),
		.run(en_r),
		.restart(restart),
		.div(div_r),
		.step(step)
	);
	stc_counter u_cnt (
		.pclk(pclk),
		.presetn(presetn),
		.ld(ld),
		.step(step),
		.count(count)
	);
	////////////////////////////////////////////////////////////////////////////////
	hold_disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!en_r && !wr_cnt) |=> count == $past(count))
		else $error("counter moved while disabled");
	en_reads_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !req.write && req.addr == STC_OFF_ENABLE) |=>
		(rsp_r.rdata == {31'h0, en_r})) else $error("enable read wrong");
	ident_const_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !req.write && req.addr == STC_OFF_IDENT) |=>
		(rsp_r.rdata == STC_IDENT_VALUE)) else $error("identity read wrong");
	live_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !req.write && req.addr == STC_OFF_COUNT) |=>
		(rsp_r.rdata == $past(count))) else $error("count read not live");
	restart_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_cnt && div_r == 3'h7) ##1 (en_r && !wr_cnt && !wr_div && !wr_en) [*7]
		|-> count == $past(count, 6)) else $error("step before full period");
	steady_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		(en_r && div_r == 3'h0 && !wr_cnt && !wr_en) |=> count == $past(count) + 32'h1)
		else $error("divider zero did not step each cycle");
	ready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready) else $error("ready held more than one cycle");
endmodule
`default_nettype wire

// *** rtl/stc_pkg.sv ***
// package: register map, field layout and constants of the timestamp counter
`default_nettype none
package stc_pkg;
	localparam int STC_ADDR_W = 12;
	localparam int STC_DATA_W = 32;
	localparam int STC_DIV_W = 3;
	localparam logic [STC_ADDR_W-1:0] STC_OFF_IDENT = 12'h000;
	localparam logic [STC_ADDR_W-1:0] STC_OFF_COUNT = 12'h010;
	localparam logic [STC_ADDR_W-1:0] STC_OFF_ENABLE = 12'h014;
	localparam logic [STC_ADDR_W-1:0] STC_OFF_DIVIDE = 12'h018;
	localparam int STC_EN_BIT = 0;
	localparam int STC_DIV_LSB = 0;
	localparam logic STC_EN_RESET = 1'b0;
	localparam logic [STC_DIV_W-1:0] STC_DIV_RESET = 3'h0;
	localparam logic [STC_DATA_W-1:0] STC_COUNT_RESET = 32'h0000_0000;
	localparam logic [STC_DATA_W-1:0] STC_COUNT_ONE = 32'h0000_0001;
	// identity fields; all values arbitrary
	localparam logic [1:0] STC_ID_SCHEME = 2'h1;
	localparam logic [11:0] STC_ID_MODULE = 12'h5a5;
	localparam logic [4:0] STC_ID_RTL = 5'h01;
	localparam logic [2:0] STC_ID_MAJOR = 3'h1;
	localparam logic [1:0] STC_ID_CUSTOM = 2'h0;
	localparam logic [5:0] STC_ID_MINOR = 6'h02;
	localparam logic [STC_DATA_W-1:0] STC_IDENT_VALUE = {STC_ID_SCHEME, 2'h0, STC_ID_MODULE,
		STC_ID_RTL, STC_ID_MAJOR, STC_ID_CUSTOM, STC_ID_MINOR};
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [STC_ADDR_W-1:0] addr;
		logic [STC_DATA_W-1:0] wdata;
	} stc_apb_req_t;
	typedef struct packed {
		logic ready;
		logic slverr;
		logic [STC_DATA_W-1:0] rdata;
	} stc_apb_rsp_t;
	typedef struct packed {
		logic load;
		logic [STC_DATA_W-1:0] value;
	} stc_load_t;
endpackage
`default_nettype wire

// *** rtl/stc_prescaler.sv ***
// prescaler: one-cycle step pulse every div+1 cycles while running
`default_nettype none
module stc_prescaler
	import stc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic restart,
	input wire logic [STC_DIV_W-1:0] div,
	output logic step
);
	logic [STC_DIV_W-1:0] cnt_r;
	logic hit;
	assign hit = (cnt_r >= div);
	assign step = run && !restart && hit;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else if (restart || !run || hit) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
		end
	end
	step_period_a: assert property (@(posedge pclk) disable iff (!presetn)
		(step && div == 3'h1 && run && !restart) ##1 (run && !restart && div == 3'h1)
		|-> !step) else $error("step came too soon for divider one");
endmodule
`default_nettype wire

// *** rtl/stc_counter.sv ***
// 32-bit counter with load and step, wraps at all ones
`default_nettype none
module stc_counter
	import stc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire stc_load_t ld,
	input wire logic step,
	output logic [STC_DATA_W-1:0] count
);
	logic [STC_DATA_W-1:0] count_r;
	assign count = count_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= STC_COUNT_RESET;
		end else if (ld.load) begin
			count_r <= ld.value;
		end else if (step) begin
			count_r <= count_r + STC_COUNT_ONE;
		end
	end
	count_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
		(step && !ld.load && count_r == 32'hffff_ffff) |=> count_r == 32'h0000_0000)
		else $error("counter did not wrap to zero");
	count_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		ld.load |=> count_r == $past(ld.value)) else $error("load value lost");
endmodule
`default_nettype wire

// *** verification/stc_top_test.sv ***
// testbench: register access, prescaled counting, load and hold of the timestamp counter
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
	$display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module stc_top_test
	import stc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [STC_ADDR_W-1:0] paddr = '0;
	logic [STC_DATA_W-1:0] pwdata = '0;
	logic [3:0] pstrb = 4'hf;
	logic pready;
	logic pslverr;
	logic [STC_DATA_W-1:0] prdata;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	logic [STC_DATA_W:0] notes[$];
	logic [31:0] seed = 32'hadb9fbef;
	always #25 pclk = ~pclk;
	stc_top stc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.pslverr(pslverr), .prdata(prdata));
	////////////////////////////////////////////////////////////////////////////////
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task tally_and_finish();
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one apb transfer; expected {pslverr, prdata} noted for the monitor
	task xfer(input logic wr, input logic [STC_ADDR_W-1:0] a, input logic [31:0] d,
		input logic [STC_DATA_W:0] exp);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		notes.push_back(exp);
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [STC_ADDR_W-1:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, '0);
	endtask
	task rd(input logic [STC_ADDR_W-1:0] a, input logic [31:0] e);
		xfer(1'b0, a, '0, {1'b0, e});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
		if (pready === 1'b1) begin
			if (notes.size() == 0)
				`CHK(1'b1, 1'b0)
			else
				`CHK({pslverr, prdata}, notes.pop_front())
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int unsigned g;
		logic [31:0] v;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(STC_OFF_ENABLE, 32'h0);
		rd(STC_OFF_DIVIDE, 32'h0);
		rd(STC_OFF_COUNT, STC_COUNT_RESET);
		wr(STC_OFF_IDENT, rnd());
		rd(STC_OFF_IDENT, STC_IDENT_VALUE);
		xfer(1'b1, 12'h004, rnd(), {1'b1, 32'h0});
		xfer(1'b0, 12'h00c, '0, {1'b1, 32'h0});
		wr(STC_OFF_ENABLE, 32'hffff_ffff);
		rd(STC_OFF_ENABLE, 32'h1);
		for (int n = 0; n < 8; n++) begin
			v = rnd();
			wr(STC_OFF_DIVIDE, {v[31:3], n[2:0]});
			rd(STC_OFF_DIVIDE, {29'h0, n[2:0]});
			// start near all ones so a long enough run crosses the wrap
			v = 32'hffff_fffe - (v & 32'h7);
			wr(STC_OFF_COUNT, v);
			g = rnd() % 40;
			repeat (g) @(posedge pclk);
			rd(STC_OFF_COUNT, v + 32'((g + 1) / (n + 1)));
			rd(STC_OFF_COUNT, v + 32'((g + 4) / (n + 1)));
			wr(STC_OFF_ENABLE, 32'h0);
			wr(STC_OFF_COUNT, 32'h0);
			repeat (g) @(posedge pclk);
			rd(STC_OFF_COUNT, 32'h0);
			rd(STC_OFF_ENABLE, 32'h0);
			wr(STC_OFF_ENABLE, 32'h1);
			repeat (g) @(posedge pclk);
			rd(STC_OFF_COUNT, 32'((g + 1) / (n + 1)));
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
